//--- rtl/phs_pkg.sv
package phs_pkg;
    // register byte offsets on the slave bus
    localparam logic [11:0] PHS_CTRL_OFS = 12'h000;
    localparam logic [11:0] PHS_STAT_OFS = 12'h004;
    localparam logic [11:0] PHS_RXDATA_OFS = 12'h008;
    localparam logic [11:0] PHS_TXDATA_OFS = 12'h00C;
    localparam logic [3:0] PHS_RXTAB_PAGE = 4'h1;
    localparam logic [3:0] PHS_TXTAB_PAGE = 4'h2;
    localparam logic [13:0] PHS_CTRL_RST = 14'h0000;
    // control field positions
    localparam int PHS_CTRL_FMT_LSB = 0;
    localparam int PHS_CTRL_ODD_BIT = 2;
    localparam int PHS_CTRL_LOOP_LSB = 3;
    localparam int PHS_CTRL_CHLP_BIT = 5;
    localparam int PHS_CTRL_CHEXT_BIT = 6;
    localparam int PHS_CTRL_CHAN_LSB = 7;
    localparam int PHS_CTRL_TMA_BIT = 12;
    localparam int PHS_CTRL_EN_BIT = 13;
    // status field positions
    localparam int PHS_STAT_TXCNT_LSB = 8;
    localparam int PHS_STAT_OVF_BIT = 16;
    localparam int PHS_STAT_UNF_BIT = 17;
    localparam int PHS_STAT_POS_LSB = 18;
    localparam int PHS_RXDATA_VALID_BIT = 31;
    // slot table entry fields
    localparam int PHS_TAB_MASK_LSB = 0;
    localparam int PHS_TAB_CHAN_LSB = 8;
    localparam int PHS_TAB_ACT_BIT = 13;
    // highway formats
    localparam logic [1:0] PHS_FMT_E1 = 2'h0;
    localparam logic [1:0] PHS_FMT_T1F = 2'h1;
    localparam logic [1:0] PHS_FMT_T1 = 2'h2;
    localparam logic [1:0] PHS_FMT_4M = 2'h3;
    // last bit position of a frame per format
    localparam logic [8:0] PHS_LAST_E1 = 9'h0FF;
    localparam logic [8:0] PHS_LAST_T1F = 9'h0C0;
    localparam logic [8:0] PHS_LAST_T1 = 9'h0BF;
    localparam logic [8:0] PHS_LAST_4M = 9'h1FF;
    // complete loop modes
    localparam logic [1:0] PHS_LOOP_NONE = 2'h0;
    localparam logic [1:0] PHS_LOOP_INT = 2'h1;
    localparam logic [1:0] PHS_LOOP_EXT = 2'h2;
    // buffers
    localparam int PHS_BUF_WORDS = 64;
    localparam int PHS_WORD_W = 13;
endpackage

//--- rtl/phs_fifo.sv
`timescale 1ns/1ps
module phs_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 64
) (
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // not empty
    input wire logic out_ready, // read acknowledge
    output logic [WIDTH-1:0] out_data, // head word
    output logic [$clog2(DEPTH):0] count // words held
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic do_wr;
    logic do_rd;

    // handshake terms from honest full and empty
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign count = cnt_reg;
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // storage array, no reset needed
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

//--- rtl/phs_top.sv
`timescale 1ns/1ps
// Function
// [R1] receive and transmit framing fully independent
// [R2] support 32-slot 2.048 Mbit/s frame
// [R3] support 24-slot 1.544/1.536 Mbit/s frames
// [R4] 4.096 Mbit/s: serve only even or odd slots
// [R5] per-slot fill mask selects used bits
// [R6] any slots grouped into one channel
// [R7] transmit pulse rise marks last frame bit; the code restarts tx_pos at bit 0 on the rise, as for receive
// [R8] receive pulse rise marks first frame bit
// [R9] framing bit ignored, transmit tristated there
// [R10] complete loop, internal or external
// [R11] single channel loop, internal or external
// [R12] masked bits dropped, or ones in mode A
// [R13] highway gives one pulse per frame
// [R14] slot shareable by four devices via masks
// [R15] transmit buffer of 64 long words
// [R16] receive buffer of 64 long words
// [R17] drive data only in active channel bits
// [R18] per-direction bit counter realigned by pulse
module phs_top (
    input wire logic clock, // 50 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, words only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    output logic [31:0] hrdata, // ahb read data
    input wire logic rx_bit_clock, // receive bit clock pin
    input wire logic rx_frame_pulse, // receive frame pulse pin
    input wire logic rx_data, // receive data pin
    input wire logic tx_bit_clock, // transmit bit clock pin
    input wire logic tx_frame_pulse, // transmit frame pulse pin
    output logic tx_data_o, // transmit data out
    output logic tx_data_oe // transmit data drive enable
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic rclk_d;
        logic tx_bit_clock_d;
        logic rfp_d;
        logic tfp_d;
        logic [13:0] ctrl;
        logic ovf;
        logic unf;
        logic [8:0] rx_pos;
        logic [8:0] tx_pos;
        logic [31:0][13:0] rx_tab;
        logic [31:0][13:0] tx_tab;
        logic [31:0][7:0] rx_sh;
        logic [31:0][2:0] rx_cnt;
        logic [7:0] tx_byte;
        logic [2:0] tx_cnt;
        logic tx_have;
        logic [4:0] tx_chan;
        logic tx_data;
        logic tx_oe;
        logic lp_bit;
        logic push_valid;
        logic [12:0] push_data;
        logic dp_pend;
        logic [11:0] dp_addr;
        logic hready;
        logic [31:0] hrdata;
    } phs_state_t;

    phs_state_t st_reg;
    phs_state_t st_next;

    logic rx_in_ready;
    logic rx_out_valid;
    logic [12:0] rx_out_data;
    logic [6:0] rx_count;
    logic rx_pop;
    logic tx_in_ready;
    logic tx_out_valid;
    logic [12:0] tx_out_data;
    logic [6:0] tx_count;
    logic tx_pop;
    logic tx_push;
    logic addr_phase;
    logic rx_edge;
    logic tx_edge;
    logic rfp_rise;
    logic tfp_rise;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // last bit position of a frame for a format
    function automatic logic [8:0] phs_last(input logic [1:0] fmt);
        case (fmt)
            phs_pkg::PHS_FMT_E1: phs_last = phs_pkg::PHS_LAST_E1;
            phs_pkg::PHS_FMT_T1F: phs_last = phs_pkg::PHS_LAST_T1F;
            phs_pkg::PHS_FMT_T1: phs_last = phs_pkg::PHS_LAST_T1;
            default: phs_last = phs_pkg::PHS_LAST_4M;
        endcase
    endfunction

    // bit position to {served, table index, bit in slot}
    function automatic logic [8:0] phs_dec(input logic [1:0] fmt, input logic odd, input logic [8:0] pos);
        logic [8:0] p;
        p = 9'h000;
        case (fmt)
            phs_pkg::PHS_FMT_T1F: begin
                p = pos - 9'h001;
                phs_dec = {(pos != 9'h000), p[7:3], p[2:0]}; // [R9] [R3]
            end
            phs_pkg::PHS_FMT_4M: begin
                phs_dec = {(pos[3] == odd), pos[8:4], pos[2:0]}; // [R4]
            end
            default: begin
                phs_dec = {1'b1, pos[7:3], pos[2:0]}; // [R2] [R3]
            end
        endcase
    endfunction

    // register read value
    function automatic logic [31:0] phs_rd(input phs_state_t s, input logic [11:0] a, input logic [6:0] rxc,
                                          input logic [6:0] txc, input logic rxv, input logic [12:0] rxd);
        phs_rd = 32'h00000000;
        if (a[11:8] == phs_pkg::PHS_RXTAB_PAGE) begin
            phs_rd = {18'h00000, s.rx_tab[a[6:2]]};
        end else if (a[11:8] == phs_pkg::PHS_TXTAB_PAGE) begin
            phs_rd = {18'h00000, s.tx_tab[a[6:2]]};
        end else begin
            case (a)
                phs_pkg::PHS_CTRL_OFS: phs_rd = {18'h00000, s.ctrl};
                phs_pkg::PHS_STAT_OFS: begin
                    phs_rd[6:0] = rxc;
                    phs_rd[phs_pkg::PHS_STAT_TXCNT_LSB +: 7] = txc;
                    phs_rd[phs_pkg::PHS_STAT_OVF_BIT] = s.ovf;
                    phs_rd[phs_pkg::PHS_STAT_UNF_BIT] = s.unf;
                    phs_rd[phs_pkg::PHS_STAT_POS_LSB +: 9] = s.rx_pos;
                end
                phs_pkg::PHS_RXDATA_OFS: begin
                    phs_rd[12:0] = rxv ? rxd : 13'h0000;
                    phs_rd[phs_pkg::PHS_RXDATA_VALID_BIT] = rxv;
                end
                default: phs_rd = 32'h00000000;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // buffers between highway and bus

    phs_fifo #(.WIDTH(phs_pkg::PHS_WORD_W), .DEPTH(phs_pkg::PHS_BUF_WORDS)) u_rx_buffer ( // [R16]
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(st_reg.push_valid),
        .in_ready(rx_in_ready),
        .in_data(st_reg.push_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .count(rx_count)
    );

    phs_fifo #(.WIDTH(phs_pkg::PHS_WORD_W), .DEPTH(phs_pkg::PHS_BUF_WORDS)) u_tx_buffer ( // [R15]
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .in_data(hwdata[12:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_out_data),
        .count(tx_count)
    );

    // bus handshake and edge terms
    assign addr_phase = hsel & htrans[1] & hready;
    assign rx_pop = addr_phase & !hwrite & (haddr[11:0] == phs_pkg::PHS_RXDATA_OFS) & rx_out_valid;
    assign tx_push = st_reg.dp_pend & (st_reg.dp_addr == phs_pkg::PHS_TXDATA_OFS) & tx_in_ready;
    assign tx_pop = !st_reg.tx_have & tx_out_valid;
    assign rx_edge = st_reg.s2[0] & !st_reg.rclk_d;
    assign tx_edge = st_reg.s2[3] & !st_reg.tx_bit_clock_d;
    assign rfp_rise = st_reg.s2[1] & !st_reg.rfp_d;
    assign tfp_rise = st_reg.s2[4] & !st_reg.tfp_d;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [1:0] fmt;
        logic [8:0] pos;
        logic [8:0] dec;
        logic [13:0] ent;
        logic bit_in;
        logic bit_out;
        logic drive;
        logic chl;
        fmt = st_reg.ctrl[phs_pkg::PHS_CTRL_FMT_LSB +: 2];
        pos = 9'h000;
        dec = 9'h000;
        ent = 14'h0000;
        bit_in = 1'b0;
        bit_out = 1'b1;
        drive = 1'b0;
        chl = 1'b0;
        st_next = st_reg;
        st_next.push_valid = 1'b0;
        // two-stage pin synchronisers, stage one read only by stage two
        st_next.s1 = {tx_frame_pulse, tx_bit_clock, rx_data, rx_frame_pulse, rx_bit_clock};
        st_next.s2 = st_reg.s1;
        st_next.rclk_d = st_reg.s2[0];
        st_next.tx_bit_clock_d = st_reg.s2[3];

        // bus data phase: register writes and transmit pushes
        if (st_reg.dp_pend) begin
            if (st_reg.dp_addr == phs_pkg::PHS_TXDATA_OFS) begin
                if (tx_in_ready) begin
                    st_next.dp_pend = 1'b0;
                    st_next.hready = 1'b1;
                end
            end else begin
                st_next.dp_pend = 1'b0;
                if (st_reg.dp_addr == phs_pkg::PHS_CTRL_OFS) begin
                    st_next.ctrl = hwdata[13:0];
                end else if (st_reg.dp_addr == phs_pkg::PHS_STAT_OFS) begin
                    st_next.ovf = st_reg.ovf & !hwdata[phs_pkg::PHS_STAT_OVF_BIT];
                    st_next.unf = st_reg.unf & !hwdata[phs_pkg::PHS_STAT_UNF_BIT];
                end else if (st_reg.dp_addr[11:8] == phs_pkg::PHS_RXTAB_PAGE) begin
                    st_next.rx_tab[st_reg.dp_addr[6:2]] = hwdata[13:0]; // [R6]
                end else if (st_reg.dp_addr[11:8] == phs_pkg::PHS_TXTAB_PAGE) begin
                    st_next.tx_tab[st_reg.dp_addr[6:2]] = hwdata[13:0]; // [R6]
                end
            end
        end
        // bus address phase: reads answer at once, transmit writes wait
        if (addr_phase) begin
            st_next.dp_pend = hwrite;
            st_next.dp_addr = haddr[11:0];
            if (hwrite && haddr[11:0] == phs_pkg::PHS_TXDATA_OFS) begin
                st_next.hready = 1'b0;
            end
            if (!hwrite) begin
                st_next.hrdata = phs_rd(st_reg, haddr[11:0], rx_count, tx_count, rx_out_valid, rx_out_data);
            end
        end

        // receive bit engine, on its own clock edges only
        if (rx_edge) begin // [R1]
            st_next.rfp_d = st_reg.s2[1];
            pos = (rfp_rise || st_reg.rx_pos == phs_last(fmt)) ? 9'h000 : st_reg.rx_pos + 9'h001; // [R8] [R18]
            st_next.rx_pos = pos;
            dec = phs_dec(fmt, st_reg.ctrl[phs_pkg::PHS_CTRL_ODD_BIT], pos);
            ent = st_reg.rx_tab[dec[7:3]];
            chl = st_reg.ctrl[phs_pkg::PHS_CTRL_CHLP_BIT] & !st_reg.ctrl[phs_pkg::PHS_CTRL_CHEXT_BIT]
                & (ent[phs_pkg::PHS_TAB_CHAN_LSB +: 5] == st_reg.ctrl[phs_pkg::PHS_CTRL_CHAN_LSB +: 5]);
            // internal loops take the last transmitted bit instead of the pin
            if (st_reg.ctrl[phs_pkg::PHS_CTRL_LOOP_LSB +: 2] == phs_pkg::PHS_LOOP_INT || chl) begin // [R10] [R11]
                bit_in = st_reg.lp_bit;
            end else begin
                bit_in = st_reg.s2[2];
            end
            if (dec[8] && ent[phs_pkg::PHS_TAB_ACT_BIT] && st_reg.ctrl[phs_pkg::PHS_CTRL_EN_BIT]) begin
                if (ent[phs_pkg::PHS_TAB_MASK_LSB + dec[2:0]] || st_reg.ctrl[phs_pkg::PHS_CTRL_TMA_BIT]) begin // [R5] [R12]
                    if (!ent[phs_pkg::PHS_TAB_MASK_LSB + dec[2:0]]) begin
                        bit_in = 1'b1; // [R12]
                    end
                    st_next.rx_sh[ent[12:8]] = {st_reg.rx_sh[ent[12:8]][6:0], bit_in};
                    st_next.rx_cnt[ent[12:8]] = st_reg.rx_cnt[ent[12:8]] + 3'h1;
                    if (st_reg.rx_cnt[ent[12:8]] == 3'h7) begin
                        st_next.push_valid = 1'b1;
                        st_next.push_data = {ent[12:8], st_reg.rx_sh[ent[12:8]][6:0], bit_in};
                    end
                end
            end
        end
        // a full receive buffer drops the byte and flags it
        if (st_reg.push_valid && !rx_in_ready) begin
            st_next.ovf = 1'b1; // [R16]
        end

        // load the next transmit byte from the buffer head
        if (tx_pop) begin
            st_next.tx_have = 1'b1;
            st_next.tx_byte = tx_out_data[7:0];
            st_next.tx_chan = tx_out_data[12:8];
            st_next.tx_cnt = 3'h0;
        end
        // transmit bit engine, independent of the receive side
        if (tx_edge) begin // [R1]
            st_next.tfp_d = st_reg.s2[4];
            pos = (tfp_rise || st_reg.tx_pos == phs_last(fmt)) ? 9'h000 : st_reg.tx_pos + 9'h001; // [R7] [R18]
            st_next.tx_pos = pos;
            dec = phs_dec(fmt, st_reg.ctrl[phs_pkg::PHS_CTRL_ODD_BIT], pos);
            ent = st_reg.tx_tab[dec[7:3]];
            // only used bits of active slots are driven, others left to sharers
            drive = dec[8] & ent[phs_pkg::PHS_TAB_ACT_BIT] & ent[phs_pkg::PHS_TAB_MASK_LSB + dec[2:0]]
                & st_reg.ctrl[phs_pkg::PHS_CTRL_EN_BIT]; // [R17] [R9] [R14] [R5]
            chl = st_reg.ctrl[phs_pkg::PHS_CTRL_CHLP_BIT] & st_reg.ctrl[phs_pkg::PHS_CTRL_CHEXT_BIT]
                & (ent[phs_pkg::PHS_TAB_CHAN_LSB +: 5] == st_reg.ctrl[phs_pkg::PHS_CTRL_CHAN_LSB +: 5]);
            if (st_reg.ctrl[phs_pkg::PHS_CTRL_LOOP_LSB +: 2] == phs_pkg::PHS_LOOP_EXT || chl) begin // [R10] [R11]
                bit_out = st_reg.s2[2];
            end else if (drive && st_reg.tx_have && st_reg.tx_chan == ent[12:8]) begin // [R6]
                bit_out = st_reg.tx_byte[7];
                st_next.tx_byte = {st_reg.tx_byte[6:0], 1'b1};
                st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
                st_next.tx_have = (st_reg.tx_cnt != 3'h7);
            end else begin
                bit_out = 1'b1;
                if (drive && !st_reg.tx_have) begin
                    st_next.unf = 1'b1;
                end
            end
            st_next.tx_data = bit_out;
            st_next.tx_oe = drive;
            st_next.lp_bit = bit_out;
        end
    end

    // single state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.ctrl <= phs_pkg::PHS_CTRL_RST;
            st_reg.hready <= 1'b1;
            st_reg.tx_data <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register, hresp tied to okay
    assign hreadyout = st_reg.hready;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign tx_data_o = st_reg.tx_data;
    assign tx_data_oe = st_reg.tx_oe;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    tx_wait_a: assert property (addr_phase && hwrite && haddr[11:0] == phs_pkg::PHS_TXDATA_OFS |=> !hreadyout)
        else $error("transmit write did not insert a wait state");
    tx_align_a: assert property (tx_edge && tfp_rise |=> st_reg.tx_pos == 9'h000) // [R7]
        else $error("transmit frame pulse did not realign to bit zero");
    rx_align_a: assert property (rx_edge && rfp_rise |=> st_reg.rx_pos == 9'h000) // [R8]
        else $error("receive frame pulse did not realign to bit zero");
    rx_wrap_a: assert property (rx_edge && !rfp_rise && st_reg.rx_pos == phs_last(st_reg.ctrl[1:0])
        && $stable(st_reg.ctrl) |=> st_reg.rx_pos == 9'h000) // [R2]
        else $error("receive counter did not wrap at frame end");
    rx_step_a: assert property (rx_edge && !rfp_rise && st_reg.rx_pos != phs_last(st_reg.ctrl[1:0])
        |=> st_reg.rx_pos == $past(st_reg.rx_pos) + 9'h001) // [R18]
        else $error("receive counter did not advance by one");
    indep_dirs_a: assert property (rx_edge && !tx_edge |=> $stable(st_reg.tx_pos)) // [R1]
        else $error("receive edge moved the transmit counter");
    fbit_tri_a: assert property (st_reg.ctrl[1:0] == phs_pkg::PHS_FMT_T1F && st_reg.tx_pos == 9'h000
        && $stable(st_reg.tx_pos) |-> !tx_data_oe) // [R9]
        else $error("framing bit was driven");
    odd_even_a: assert property (tx_data_oe && st_reg.ctrl[1:0] == phs_pkg::PHS_FMT_4M && $stable(st_reg.ctrl)
        |-> st_reg.tx_pos[3] == st_reg.ctrl[phs_pkg::PHS_CTRL_ODD_BIT]) // [R4]
        else $error("slot of the wrong parity was driven");
    drive_en_a: assert property (tx_data_oe && $stable(st_reg.ctrl) |-> st_reg.ctrl[phs_pkg::PHS_CTRL_EN_BIT]) // [R17]
        else $error("data driven while disabled");
    ovf_set_a: assert property (st_reg.push_valid && !rx_in_ready |=> st_reg.ovf) // [R16]
        else $error("dropped receive byte not flagged");

    tx_frame_c: cover property (tx_edge && tfp_rise);
    rx_push_c: cover property (st_reg.push_valid && rx_in_ready);
    tx_stall_c: cover property (st_reg.dp_pend && !tx_in_ready);
    tx_drive_c: cover property (tx_data_oe && st_reg.tx_have);
endmodule

//--- sim/phs_highway_model.sv
`timescale 1ns/1ps
// behavioural pcm highway for one direction, 256-bit frames
module phs_highway_model #(
    parameter int START_NS = 0
) (
    output logic bit_clock, // free running bit clock
    output logic frame_pulse, // high during the first bit
    output logic data_out, // serial data to the block
    input wire logic data_in, // serial data from the block
    input wire logic data_oe // block drives data_in
);
    int pos = 0;
    int last = 0;
    int frames = 0;
    int stray = 0;
    int slot = 1;
    logic [7:0] byte_out = 8'h00;
    logic [7:0] byte_in = 8'h00;
    logic [7:0] got = 8'hFF;
    ////////////////////////////////////////
    // highway clock runs free, phase set by START_NS
    initial begin
        bit_clock = 1'b0;
        frame_pulse = 1'b0;
        data_out = 1'b1;
        #(START_NS);
        forever #80 bit_clock = ~bit_clock;
    end
    // launch on the falling edge so the block samples settled levels
    always @(negedge bit_clock) begin
        last = pos;
        pos = (pos + 1) % 256;
        if (pos == 0) frames++;
        frame_pulse <= (pos == 0);
        data_out <= (pos / 8 == slot) ? byte_out[7 - pos % 8] : ~data_out;
    end
    // block bit launched after the previous rise is settled by this rise
    always @(posedge bit_clock) begin
        if (data_oe === 1'b1 && last / 8 != slot) stray++;
        if (last / 8 == slot) byte_in[7 - last % 8] = data_in;
        if (last / 8 == slot && last % 8 == 7 && byte_in !== 8'hFF) got = byte_in;
    end
endmodule

//--- sim/pcm_highway_serial_port_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pcm_highway_serial_port_tb;
    logic clock = 1'b0;
    logic rst_n, hsel, hwrite, hreadyout, hresp, rxc, rxf, rxd, txc, txf, txo, txoe;
    logic [31:0] haddr, hwdata, hrdata, q, last, a, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] b, m;
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 84524;
    ////////////////////////////////////////
    // 50 MHz system clock
    always #10 clock = ~clock;
    phs_top uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_bit_clock(rxc), .rx_frame_pulse(rxf), .rx_data(rxd), .tx_bit_clock(txc),
        .tx_frame_pulse(txf), .tx_data_o(txo), .tx_data_oe(txoe));
    phs_highway_model #(.START_NS(0)) rxm (.bit_clock(rxc), .frame_pulse(rxf), .data_out(rxd), .data_in(1'b1),
        .data_oe(1'b0));
    phs_highway_model #(.START_NS(37)) txm (.bit_clock(txc), .frame_pulse(txf), .data_out(), .data_in(txo),
        .data_oe(txoe));
    ////////////////////////////////////////
    // one single word transfer, holding each phase until hready
    task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 2000);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 2000);
        q = hrdata;
        if (n >= 2000) bad_count++;
    endtask
    // wait for k highway frames
    task automatic frames(input int k);
        int t;
        t = rxm.frames + k;
        while (rxm.frames < t) @(posedge clock);
    endtask
    // empty the receive buffer, keeping the newest valid word
    task automatic drain();
        last = 32'h0;
        for (int i = 0; i < 70; i++) begin
            bus(1'b0, 32'h008, 32'h0);
            if (q[31] === 1'b1) last = q;
        end
    endtask
    // expected byte when masked bits are taken as ones
    function automatic logic [7:0] fill_a(input logic [7:0] d, input logic [7:0] mk);
        for (int k = 0; k < 8; k++) fill_a[7 - k] = mk[k] ? d[7 - k] : 1'b1;
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(1'b0, 32'h004, 32'h0);
        `CHK("status reset", 32'h0, q & 32'h37F7F)
        bus(1'b0, 32'h800, 32'h0);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 64; i++) begin
            a = 32'(i < 32 ? 256 + 4 * i : 512 + 4 * (i - 32));
            v = $random(seed) & 32'h3FFF;
            bus(1'b1, a, v);
            bus(1'b0, a, 32'h0);
            `CHK("slot entry", v, q)
            bus(1'b1, a, 32'h0);
        end
        $display("slot tables done");
        rxm.byte_out = 8'($random(seed)) & 8'hFE;
        // switch modes far from slot 1 so the byte counter stays aligned
        wait (rxm.pos == 128);
        @(posedge clock);
        bus(1'b1, 32'h104, 32'h23FF);
        bus(1'b1, 32'h000, 32'h2000);
        frames(3);
        drain();
        `CHK("rx word", {1'b1, 18'h0, 5'h03, rxm.byte_out}, last)
        m = 8'($random(seed)) | 8'h01;
        wait (rxm.pos == 128);
        @(posedge clock);
        bus(1'b1, 32'h104, {18'h0, 6'h23, m});
        bus(1'b1, 32'h000, 32'h3000);
        frames(3);
        drain();
        `CHK("rx mode a", {1'b1, 18'h0, 5'h03, fill_a(rxm.byte_out, m)}, last)
        $display("receive done");
        // one word waits in the serialiser, the other 64 fill the buffer
        for (int i = 0; i < 65; i++) bus(1'b1, 32'h00C, {19'h0, 5'h05, 8'($random(seed))});
        bus(1'b0, 32'h004, 32'h0);
        `CHK("tx full", 32'h4000, q & 32'h7F00)
        `CHK("response", 1'b0, hresp)
        for (int i = 0; i < 32; i++) bus(1'b1, 32'(512 + 4 * i), 32'h25FF);
        frames(4);
        bus(1'b0, 32'h004, 32'h0);
        `CHK("tx drained", 32'h20000, q & 32'h27F00)
        for (int i = 0; i < 32; i++) bus(1'b1, 32'(512 + 4 * i), (i == 2) ? 32'h25FF : 32'h0);
        frames(1);
        txm.slot = 2;
        txm.stray = 0;
        txm.got = 8'hFF;
        b = $random(seed) & 8'hFE;
        bus(1'b1, 32'h00C, {19'h0, 5'h05, b});
        frames(2);
        `CHK("tx byte", b, txm.got)
        `CHK("tx stray", 0, txm.stray)
        $display("transmit done");
        // odd slots of a 4.096 highway: table entry 1 is line slot 3
        for (int i = 1; i < 3; i++) bus(1'b1, 32'(512 + 4 * i), (i == 1) ? 32'h25FF : 32'h0);
        bus(1'b1, 32'h000, 32'h3007);
        frames(1);
        txm.slot = 3;
        txm.stray = 0;
        txm.got = 8'hFF;
        b = 8'($random(seed)) & 8'hFE;
        bus(1'b1, 32'h00C, {19'h0, 5'h05, b});
        frames(2);
        `CHK("odd slot byte", b, txm.got)
        `CHK("odd slot stray", 0, txm.stray)
        $display("odd slots done");
        // external loop sends the receive pin out in driven bits
        bus(1'b1, 32'h000, 32'h2010);
        frames(1);
        txm.slot = 1;
        txm.stray = 0;
        txm.got = 8'hFF;
        frames(2);
        `CHK("loop byte", rxm.byte_out, txm.got)
        `CHK("loop stray", 0, txm.stray)
        $display("loop done");
        finish_test();
    end
    // cut a hang short well past the frames of the run
    initial begin
        #1_500_000;
        bad_count++;
        finish_test();
    end
endmodule
